// *** logic/hfadc_host.sv ***
// Purpose: host controller driving a half-flash converter through its pins
// Assumes: converter pins synchronous to aclk; mode strap is static
// Notes: software starts a conversion over AXI4-Lite and reads the result
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module hfadc_host
    import hfadc_pkg::*;
#(
    parameter int WR_MAX = WR_MAX_CYC,
    parameter int RDONLY_MAX = RDONLY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    input wire logic mode,
    input wire logic done_n,
    input wire logic rdy,
    input wire logic overrange_n,
    input wire logic [7:0] result_bus
);
    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    typedef enum {
        S_IDLE, S_WR_LOW, S_WR_GAP, S_RD_LOW, S_RO_WAIT, S_RECOVER
    } hfadc_state_t;

    hfadc_state_t state_ff, nxt_state;
    logic cs_n_ff, nxt_cs_n;
    logic rd_n_ff, nxt_rd_n;
    logic wr_n_ff, nxt_wr_n;
    logic [7:0] data_ff, nxt_data;
    logic ovr_ff, nxt_ovr;
    logic done_ff, nxt_done;
    logic tmo_ff, nxt_tmo;
    logic waitflag_ff, nxt_waitflag;
    logic tload;
    logic [CNT_W-1:0] tval;
    logic tdone;
    logic start_req;
    logic [CNT_W-1:0] ro_cnt_ff, nxt_ro_cnt;

    hfadc_timer #(.W(CNT_W)) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(tload),
        .value(tval),
        .done(tdone)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_cs_n = cs_n_ff;
        nxt_rd_n = rd_n_ff;
        nxt_wr_n = wr_n_ff;
        nxt_data = data_ff;
        nxt_ovr = ovr_ff;
        nxt_done = done_ff;
        nxt_tmo = tmo_ff;
        nxt_ro_cnt = ro_cnt_ff;
        tload = 1'b0;
        tval = '0;
        case (state_ff)
            S_IDLE: begin
                if (start_req) begin
                    nxt_done = 1'b0;
                    nxt_tmo = 1'b0;
                    nxt_cs_n = 1'b0;
                    if (mode) begin
                        nxt_wr_n = 1'b0;
                        tload = 1'b1;
                        tval = CNT_W'((WR_LOW_CYC < WR_MAX) ? WR_LOW_CYC : WR_MAX);
                        nxt_state = S_WR_LOW;
                    end else begin
                        nxt_rd_n = 1'b0;
                        nxt_ro_cnt = CNT_W'(RDONLY_MAX);
                        nxt_state = S_RO_WAIT;
                    end
                end
            end
            S_WR_LOW: begin
                if (tdone) begin
                    nxt_wr_n = 1'b1;
                    tload = 1'b1;
                    tval = CNT_W'(RD_WAIT_CYC);
                    nxt_state = S_WR_GAP;
                end
            end
            S_WR_GAP: begin
                if (tdone && (!waitflag_ff || !done_n)) begin
                    nxt_rd_n = 1'b0;
                    nxt_state = S_RD_LOW;
                end
            end
            S_RD_LOW: begin
                if (!done_n) begin
                    nxt_data = result_bus;
                    nxt_ovr = !overrange_n;
                    nxt_done = 1'b1;
                    nxt_rd_n = 1'b1;
                    nxt_cs_n = 1'b1;
                    tload = 1'b1;
                    tval = CNT_W'(RECOVER_CYC);
                    nxt_state = S_RECOVER;
                end
            end
            S_RO_WAIT: begin
                if (rdy || !done_n) begin
                    nxt_data = result_bus;
                    nxt_ovr = !overrange_n;
                    nxt_done = 1'b1;
                    nxt_rd_n = 1'b1;
                    nxt_cs_n = 1'b1;
                    tload = 1'b1;
                    tval = CNT_W'(RECOVER_CYC);
                    nxt_state = S_RECOVER;
                end else if (ro_cnt_ff == '0) begin
                    nxt_tmo = 1'b1;
                    nxt_rd_n = 1'b1;
                    nxt_cs_n = 1'b1;
                    tload = 1'b1;
                    tval = CNT_W'(RECOVER_CYC);
                    nxt_state = S_RECOVER;
                end else begin
                    nxt_ro_cnt = ro_cnt_ff - CNT_W'(1);
                end
            end
            S_RECOVER: begin
                if (tdone) begin
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= S_IDLE;
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            data_ff <= 8'h00;
            ovr_ff <= 1'b0;
            done_ff <= 1'b0;
            tmo_ff <= 1'b0;
            ro_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cs_n_ff <= nxt_cs_n;
            rd_n_ff <= nxt_rd_n;
            wr_n_ff <= nxt_wr_n;
            data_ff <= nxt_data;
            ovr_ff <= nxt_ovr;
            done_ff <= nxt_done;
            tmo_ff <= nxt_tmo;
            ro_cnt_ff <= nxt_ro_cnt;
        end
    end

    assign cs_n = cs_n_ff;
    assign rd_n = rd_n_ff;
    assign wr_n = wr_n_ff;

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    logic aw_ff, nxt_aw;
    logic w_ff, nxt_w;
    logic [3:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic do_write;

    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign do_write = aw_ff && w_ff && !bvalid_ff;
    // start only counts when idle; a start written while busy is dropped, though the wait flag is still written
    assign start_req = do_write && (awaddr_ff == REG_CTRL) && wstrb0_ff &&
        wdata_ff[CTRL_START] && (state_ff == S_IDLE);

    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_waitflag = waitflag_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (awaddr_ff == REG_CTRL) begin
                if (wstrb0_ff) begin
                    nxt_waitflag = wdata_ff[CTRL_WAITFLAG];
                end
            end else if (awaddr_ff != REG_STAT && awaddr_ff != REG_DATA) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            case (s_axi_araddr)
                REG_CTRL: nxt_rdata[CTRL_WAITFLAG] = waitflag_ff;
                REG_STAT: begin
                    nxt_rdata[STAT_BUSY] = (state_ff != S_IDLE);
                    nxt_rdata[STAT_DONE] = done_ff;
                    nxt_rdata[STAT_OVR] = ovr_ff;
                    nxt_rdata[STAT_MODE] = mode;
                    nxt_rdata[STAT_TMO] = tmo_ff;
                end
                REG_DATA: nxt_rdata[7:0] = data_ff;
                default: nxt_rresp = RESP_SLVERR;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            waitflag_ff <= 1'b0;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            waitflag_ff <= nxt_waitflag;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule // hfadc_host

// *** logic/hfadc_pkg.sv ***
// Purpose: constants for the half-flash converter host controller
// Assumes: aclk at 125 MHz
// Notes: the converter's own registers are none; all control is through pins
// Summary of operation
// - write-read mode: convert strobe low at least 600 ns starts the conversion.
// - write-read mode: read strobe falls at least 600 ns after convert strobe rises.
// - read-only mode: host holds read strobe low until data appears (this host releases it after 2500 ns and sets the timeout flag).
// - stand-alone: select and read held low, data valid 800 ns after strobe.
// - convert strobe low no longer than 50 us.
// - next conversion waits at least 500 ns for upper bank zeroing.
// - strobes are ignored unless chip select is low.
package hfadc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int WR_LOW_MIN_NS = 600;
    localparam int WR_LOW_MAX_NS = 50000;
    localparam int RD_AFTER_WR_NS = 600;
    localparam int RECOVER_NS = 500;
    localparam int RDONLY_TMO_NS = 2500;
    localparam int WR_LOW_CYC = (WR_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_MAX_CYC = (WR_LOW_MAX_NS * CLK_MHZ) / 1000;
    localparam int RD_WAIT_CYC = (RD_AFTER_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int RDONLY_CYC = (RDONLY_TMO_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 16;
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    // ctrl field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_WAITFLAG = 1;
    // status field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_OVR = 2;
    localparam int STAT_MODE = 3;
    localparam int STAT_TMO = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/hfadc_timer.sv ***
// Purpose: load-and-count-down timer for strobe timing
// Assumes: load takes priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module hfadc_timer
    import hfadc_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = value;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign done = (cnt_ff == '0);
endmodule // hfadc_timer

// *** tb/hfadc_conv_model.sv ***
// Purpose: behavioural half-flash converter seen from its pins
// Assumes: HALF cycles per 800 ns conversion half
// Notes: stall keeps a read-only conversion from ever finishing
`timescale 1ns/1ps
module hfadc_conv_model #(
    parameter int HALF = 100
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic mode,
    input wire logic stall,
    input wire logic [8:0] vin,
    output logic done_n,
    output logic rdy,
    output logic overrange_n,
    output logic [7:0] result_bus
);
// ----
// conversion sequencing
// ----
logic [8:0] smp, res, cnt;
logic run, fin, wr_q, rd_q, sel_rd, sel_wr;
assign sel_rd = !cs_n && !rd_n;
assign sel_wr = !cs_n && !wr_n;
// inverse when released, so a stale value never passes
assign result_bus = sel_rd ? res[7:0] : ~res[7:0];
assign rdy = !(sel_rd && !fin && !mode);
always @(posedge aclk) begin
    if (!aresetn) begin
        {run, fin, done_n, overrange_n, wr_q, rd_q} <= 6'h0F;
        cnt <= 9'h0;
        smp <= 9'h0;
        res <= 9'h0;
    end else begin
        wr_q <= !sel_wr;
        rd_q <= !sel_rd;
        if (mode && sel_wr) smp <= vin;
        if (mode && !wr_q && !sel_wr) begin
            run <= 1'b1;
            cnt <= 9'(HALF);
        end
        if (!mode && rd_q && sel_rd) begin
            smp <= vin;
            run <= 1'b1;
            cnt <= 9'(2 * HALF);
        end
        if (run && cnt != 9'h0) cnt <= cnt - 9'h1;
        if (run && ((cnt == 9'h1 && !stall) || (mode && rd_q && sel_rd))) begin
            run <= 1'b0;
            fin <= 1'b1;
            done_n <= 1'b0;
            res <= smp;
            overrange_n <= !smp[8];
        end
        if (!rd_q && !sel_rd) begin
            done_n <= 1'b1;
            fin <= 1'b0;
            if (!mode) run <= 1'b0;
        end
    end
end
endmodule // hfadc_conv_model

// *** tb/hfadc_host_bench.sv ***
// Purpose: self-checking bench for the converter host controller
// Assumes: converter model answers in 800 ns halves
// Notes: mode strap changes only under reset
`timescale 1ns/1ps
module hfadc_host_bench
    import hfadc_pkg::*;
;
logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mode, stall;
logic awready, wready, bvalid, arready, rvalid, cs_n, rd_n, wr_n, done_n, rdy, ovr_n;
logic [3:0] awaddr, araddr, wstrb;
logic [31:0] wdata, rdata, got;
logic [1:0] bresp, rresp, resp;
logic [7:0] dbus;
logic [8:0] vin;
int miscompares, check_count;
initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
end
hfadc_host u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .mode(mode), .done_n(done_n), .rdy(rdy),
    .overrange_n(ovr_n), .result_bus(dbus)
);
hfadc_conv_model u_conv (
    .aclk(aclk), .aresetn(aresetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .mode(mode),
    .stall(stall), .vin(vin), .done_n(done_n), .rdy(rdy), .overrange_n(ovr_n),
    .result_bus(dbus)
);
// ----
// access tasks
// ----
task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, act);
    end
endtask
task automatic hang();
    miscompares++;
    $display("[FAIL] handshake expected answer seen none");
    tally_and_finish();
endtask
task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    if (n == 100) hang();
    resp = bresp;
    bready <= 1'b0;
endtask
task automatic axr(input logic [3:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    if (n == 100) hang();
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
endtask
task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++) begin
        axr(REG_STAT);
        if (got[STAT_BUSY] === 1'b0) break;
    end
    if (n == 400) hang();
endtask
task automatic conv(input logic [31:0] ctl, input logic [8:0] v, input logic [31:0] st);
    vin <= v;
    axw(REG_CTRL, ctl);
    axr(REG_STAT);
    chk("busy", 32'h1, got & 32'h1);
    wait_idle();
    axr(REG_DATA);
    chk("data", {24'h0, v[7:0]}, got);
    axr(REG_STAT);
    chk("status", st, got);
endtask
// ----
// scenarios
// ----
initial begin
    aresetn = 1'b0;
    awaddr = 4'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    wstrb = 4'hF;
    bready = 1'b0;
    araddr = 4'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    mode = 1'b1;
    stall = 1'b0;
    vin = 9'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_STAT);
    chk("status after reset", 32'h8, got);
    axr(4'hC);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axw(4'hC, 32'h1);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // early read before the completion flag, then flag-driven reads back to back
    conv(32'h1, 9'h05A, 32'h0A);
    conv(32'h3, 9'h1A5, 32'h0E);
    conv(32'h3, 9'h0FF, 32'h0A);
    // a start with its byte lane masked must neither start nor touch the wait flag
    wstrb <= 4'h0;
    axw(REG_CTRL, 32'h1);
    axr(REG_STAT);
    chk("masked start", 32'h0, got & 32'h1);
    axr(REG_CTRL);
    chk("masked ctrl", 32'h2, got);
    wstrb <= 4'hF;
    @(posedge aclk);
    aresetn <= 1'b0;
    mode <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    conv(32'h1, 9'h03C, 32'h02);
    stall <= 1'b1;
    axw(REG_CTRL, 32'h1);
    wait_idle();
    axr(REG_STAT);
    chk("timeout", 32'h10, got & 32'h10);
    tally_and_finish();
end
endmodule // hfadc_host_bench

// *** tb/hfadc_host_checker.sv ***
// Purpose: pin timing assertions for the converter host controller
// Assumes: counts in aclk cycles taken from the package
// Notes: bound into hfadc_host
`timescale 1ns/1ps
module hfadc_host_checker
    import hfadc_pkg::*;
#(
    parameter int RDONLY_MAX = RDONLY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic mode,
    input wire logic done_n,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
// ----
// strobe counters
// ----
logic [15:0] wl_ff, sw_ff, ih_ff, rl_ff;
logic [15:0] nxt_wl, nxt_sw, nxt_ih, nxt_rl;
always_comb begin
    nxt_wl = wr_n ? 16'h0 : wl_ff + 16'h1;
    nxt_sw = !wr_n ? 16'h0 : sw_ff + {15'h0, ~&sw_ff};
    nxt_ih = !cs_n ? 16'h0 : ih_ff + {15'h0, ~&ih_ff};
    nxt_rl = rd_n ? 16'h0 : rl_ff + 16'h1;
end
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        wl_ff <= 16'h0;
        sw_ff <= 16'h0;
        // start saturated so the first conversion is not held back
        ih_ff <= 16'hFFFF;
        rl_ff <= 16'h0;
    end else begin
        wl_ff <= nxt_wl;
        sw_ff <= nxt_sw;
        ih_ff <= nxt_ih;
        rl_ff <= nxt_rl;
    end
end
// ----
// properties
// ----
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_wr_end;
    $rose(wr_n);
endsequence
sequence s_rd_done;
    !rd_n && !done_n;
endsequence
// the strobe rises on the edge after the timer empties, so it stands one cycle past the load
chk_wr_width:
assert property (s_wr_end |-> wl_ff == 16'(WR_LOW_CYC + 1)) else $error("convert strobe width");
chk_rd_gap:
assert property ($fell(rd_n) && mode |-> sw_ff >= 16'(RD_WAIT_CYC)) else $error("read too early");
chk_cs_gate:
assert property (!rd_n || !wr_n |-> !cs_n) else $error("strobe without select");
chk_wr_mode:
assert property (!wr_n |-> mode) else $error("convert strobe in read-only mode");
chk_recover_gap:
assert property ($fell(cs_n) |-> ih_ff >= 16'(RECOVER_CYC)) else $error("restart too soon");
chk_rd_release:
assert property (s_rd_done |-> ##[1:3] (rd_n && cs_n)) else $error("read not released");
chk_ro_limit:
assert property (rl_ff <= 16'(RDONLY_MAX + 4)) else $error("read held too long");
chk_ar_refuse:
assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during answer");
endmodule // hfadc_host_checker

bind hfadc_host hfadc_host_checker #(.RDONLY_MAX(RDONLY_MAX)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .mode(mode),
    .done_n(done_n), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
